//--- include/fp_cfg.svh
// Purpose: offsets, field positions, reset values and timing of the panel
// Assumes: 100 MHz core clock
// Notes:   included by bare name; definitions only
`ifndef FP_CFG_SVH
`define FP_CFG_SVH

// ----------------------------------------------------------------------
// register port offsets
// ----------------------------------------------------------------------
`define FP_OFS_SWITCH   4'h0
`define FP_OFS_LAMP     4'h4
`define FP_OFS_STATUS   4'h8

// ----------------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------------
`define FP_ST_STOP      0
`define FP_ST_DECODE    1
`define FP_ST_INT       2
`define FP_ST_PAGING    3
`define FP_ST_LVL_LSB   4
`define FP_ST_SRC_LSB   8
`define FP_ST_LVL_OUT   12

// ----------------------------------------------------------------------
// switch and address fields
// ----------------------------------------------------------------------
`define FP_SW_PT_LSB    16
`define FP_SEG_LSB      12

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FP_RST_ADDR     18'h0_0000
`define FP_RST_WORD     16'h0000
`define FP_RST_LEVEL    4'h0
`define FP_RESTART_ADDR 16'h0014

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FP_CLK_NS       10
`define FP_TICK_US      2500
`define FP_GLOW_US      20000

`endif

//--- include/fp_pkg.sv
// Purpose: shared types of the operator panel
// Assumes: nothing
// Notes:   per-level sources sit at 8..15 so the low bits give the code
package fp_pkg;

  // display sources; low three bits of 8..15 are the register code
  typedef enum logic [3:0] {
    FP_SRC_ACTIVE = 4'h0,
    FP_SRC_DMA    = 4'h1,
    FP_SRC_ADR    = 4'h2,
    FP_SRC_PADR   = 4'h3,
    FP_SRC_USER   = 4'h4,
    FP_SRC_DATA   = 4'h5,
    FP_SRC_EXM    = 4'h6,
    FP_SRC_IR     = 4'h7,
    FP_SRC_STS    = 4'h8,
    FP_SRC_D      = 4'h9,
    FP_SRC_P      = 4'ha,
    FP_SRC_B      = 4'hb,
    FP_SRC_L      = 4'hc,
    FP_SRC_A      = 4'hd,
    FP_SRC_T      = 4'he,
    FP_SRC_X      = 4'hf
  } fp_src_t;

endpackage : fp_pkg

//--- include/fp_dec_if.sv
// Purpose: carrier between panel core and the segment decoder
// Assumes: 18-bit addresses, 18 lamps
// Notes:   combinational path only
`timescale 1ns/1ns
interface fp_dec_if;
  logic [17:0] addr;
  logic [17:0] seg;

  modport src (output addr, input  seg);
  modport dec (input  addr, output seg);
endinterface : fp_dec_if

//--- verilog/fp_seg_dec.sv
// Purpose: lights the one lamp whose 4K segment holds an address
// Assumes: segments beyond lamp 17 light nothing
// Notes:   pure combinational
`timescale 1ns/1ns
`include "fp_cfg.svh"
module fp_seg_dec (
  fp_dec_if.dec dec
);

  // one-hot of the segment number
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      dec.seg[i] = (dec.addr[17:`FP_SEG_LSB] == 6'(i));
    end
  end

endmodule : fp_seg_dec

//--- verilog/fp_glow.sv
// Purpose: afterglow stretcher for one level lamp
// Assumes: hit_i is a level from the core clock domain
// Notes:   glow restarts on every hit
`timescale 1ns/1ns
`include "fp_cfg.svh"
module fp_glow #(
  parameter int W   = 21,
  parameter int CYC = 2000000
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic hit_i,
  output logic      glow_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         lit;
  } fp_glow_st_t;

  fp_glow_st_t s_reg;
  fp_glow_st_t s_next;

  // reload on a hit, otherwise count down
  always_comb begin
    s_next = s_reg;
    if (hit_i) begin
      s_next.cnt = W'(CYC);
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    s_next.lit = hit_i || (s_reg.cnt > W'(1));
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign glow_o = s_reg.lit;

endmodule : fp_glow

//--- verilog/fp_panel.sv
// Purpose: operator front panel controller of a 16-bit minicomputer
// Assumes: buttons and cpu inputs are one-cycle, synchronous to clk_i
// Notes:   examine and per-level words refresh only when the panel tick is serviced
//
// Summary of operation
// - eighteen-bit switch word readable by program
// - paging on: switches 16-17 give table
// - lamps show data; user word via write
// - sixteen selectors pick one source, lamp lit
// - active levels shown with afterglow lamps
// - operand and fetch addresses captured separately
// - user write overwrites any shown value
// - stop examine address, cleared entering stop
// - running examine uses switches, sampled every cycle
// - per-level register sampled when a tick is serviced
// - level steps; outside range uses active level
// - master clear pulses clear, pie, microprogram
// - error lights clear lamp until pressed
// - restart only in stop, address twenty
// - load starts autoload, lamp while active
// - decode mode lights one 4K segment
// - set address latches switches in stop
// - deposit writes switches only under examine
// - enter stores switches into chosen register
// - single step on level from pie, pid
// - continue and stop requests with lamps
// - interrupt and paging mode indicators
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "fp_cfg.svh"
module fp_panel #(
  parameter int CNT_W    = 18,
  parameter int TICK_CYC = `FP_TICK_US * 1000 / `FP_CLK_NS,
  parameter int GLOW_W   = 21,
  parameter int GLOW_CYC = `FP_GLOW_US * 1000 / `FP_CLK_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // operator side
  input  wire logic [17:0] sw_i,
  input  wire logic [15:0] sel_btn_i,
  input  wire logic        btn_mclear_i,
  input  wire logic        btn_restart_i,
  input  wire logic        btn_load_i,
  input  wire logic        btn_decode_i,
  input  wire logic        btn_set_addr_i,
  input  wire logic        btn_deposit_i,
  input  wire logic        btn_enter_i,
  input  wire logic        btn_single_i,
  input  wire logic        btn_cont_i,
  input  wire logic        btn_stop_i,
  input  wire logic        btn_plus_i,
  input  wire logic        btn_minus_i,
  input  wire logic [15:0] load_descriptor_switches_i,
  // cpu side
  input  wire logic        cpu_stop_i,
  input  wire logic [3:0]  active_level_i,
  input  wire logic [15:0] priority_irq_enable_reg_i,
  input  wire logic [15:0] priority_irq_detect_reg_i,
  input  wire logic [17:0] dma_addr_i,
  input  wire logic        ref_valid_i,
  input  wire logic        ref_dma_i,
  input  wire logic        ref_fetch_i,
  input  wire logic [17:0] ref_addr_i,
  input  wire logic        data_valid_i,
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] instruction_register_view_i,
  input  wire logic        panel_ack_i,
  input  wire logic [15:0] exm_word_i,
  input  wire logic [15:0] level_word_i,
  input  wire logic        console_exam_i,
  input  wire logic [17:0] console_addr_i,
  input  wire logic        error_i,
  input  wire logic        load_active_i,
  input  wire logic        interrupts_on_instruction_i,
  input  wire logic        interrupts_off_i,
  input  wire logic        paging_on_instruction_i,
  input  wire logic        paging_off_i,
  // register port
  input  wire logic [3:0]  bus_addr_i,
  input  wire logic [15:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  output logic      [17:0] bus_rdata_o,
  // lamps
  output logic      [17:0] lamps_o,
  output logic      [15:0] sel_lamps_o,
  output logic      [3:0]  level_disp_o,
  output logic             mclear_lamp_o,
  output logic             load_lamp_o,
  output logic             decode_lamp_o,
  output logic             cont_lamp_o,
  output logic             stop_lamp_o,
  output logic             int_lamp_o,
  output logic             paging_lamp_o,
  // requests to the cpu and microprogram
  output logic             panel_irq_o,
  output logic      [17:0] exam_addr_o,
  output logic      [1:0]  page_table_o,
  output logic      [3:0]  rd_level_o,
  output logic      [2:0]  rd_reg_o,
  output logic      [15:0] wdata_o,
  output logic             mem_wr_o,
  output logic             reg_wr_o,
  output logic             mclear_o,
  output logic             pie_clear_o,
  output logic             operator_comm_microprogram_o,
  output logic             restart_o,
  output logic      [15:0] start_addr_o,
  output logic             load_o,
  output logic      [15:0] load_desc_o,
  output logic             single_o,
  output logic             cont_o,
  output logic             stop_o,
  output logic      [3:0]  run_level_o
);

  typedef struct packed {
    logic [CNT_W-1:0] tick_cnt;
    logic             irq;
    fp_pkg::fp_src_t  src;
    logic [15:0]      sel_lamps;
    logic [3:0]       lvl;
    logic             lvl_out;
    logic [3:0]       lvl_disp;
    logic             decode;
    logic             was_stop;
    logic [17:0]      exam_latch;
    logic [17:0]      exam_addr;
    logic [1:0]       page_table;
    logic [17:0]      lamps;
    logic [15:0]      user;
    logic [17:0]      adr;
    logic [17:0]      padr;
    logic [15:0]      data;
    logic [15:0]      exm_word;
    logic [15:0]      lvl_word;
    logic             mc_lamp;
    logic             load_lamp;
    logic             int_lamp;
    logic             pg_lamp;
    logic [17:0]      rdata;
    logic [3:0]       rd_level;
    logic [2:0]       rd_reg;
    logic [15:0]      wdata;
    logic             mem_wr;
    logic             reg_wr;
    logic             mclear;
    logic             pie_clr;
    logic             comm;
    logic             restart;
    logic [15:0]      start_addr;
    logic             load;
    logic [15:0]      load_desc;
    logic             single;
    logic             cont;
    logic             stop;
    logic [3:0]       run_level;
  } fp_panel_st_t;

  fp_panel_st_t s_reg;
  fp_panel_st_t s_next;

  logic [15:0] glow;
  fp_dec_if    dec_bus ();

  // ----------------------------------------------------------------------
  // level afterglow lamps
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_glow
      fp_glow #(
        .W   (GLOW_W),
        .CYC (GLOW_CYC)
      ) u_glow (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .hit_i  (!cpu_stop_i && (active_level_i == 4'(g))),
        .glow_o (glow[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // segment decoder for address sources
  // ----------------------------------------------------------------------
  // address chosen for decode
  assign dec_bus.addr = (s_reg.src == fp_pkg::FP_SRC_DMA)  ? dma_addr_i :
                        (s_reg.src == fp_pkg::FP_SRC_PADR) ? s_reg.padr :
                                                             s_reg.adr;

  fp_seg_dec u_dec (
    .dec (dec_bus)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic        tick;
  logic        pick;
  logic [3:0]  pick_idx;
  logic [3:0]  eff_lvl;
  logic [3:0]  pie_lvl;
  logic        stop_enter;
  logic        lamp_wr;
  logic        paging;
  logic [17:0] exam_src;
  logic [17:0] disp;

  always_comb begin
    s_next = s_reg;
    // pulses fall back every cycle
    s_next.mem_wr  = 1'b0;
    s_next.reg_wr  = 1'b0;
    s_next.mclear  = 1'b0;
    s_next.pie_clr = 1'b0;
    s_next.comm    = 1'b0;
    s_next.restart = 1'b0;
    s_next.load    = 1'b0;
    s_next.single  = 1'b0;
    s_next.cont    = 1'b0;
    s_next.stop    = 1'b0;

    tick = (s_reg.tick_cnt == CNT_W'(TICK_CYC - 1));
    s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 1'b1;
    if (panel_ack_i) begin
      s_next.irq = 1'b0;
    end
    if (tick) begin
      s_next.irq = 1'b1;
    end

    pick     = 1'b0;
    pick_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (sel_btn_i[i]) begin
        pick     = 1'b1;
        pick_idx = 4'(i);
      end
    end
    if (pick) begin
      s_next.src = fp_pkg::fp_src_t'(pick_idx);
    end
    s_next.sel_lamps = 16'h0001 << s_next.src;

    // step level, leave range at ends
    if (btn_plus_i) begin
      if (s_reg.lvl_out) begin
        s_next.lvl_out = 1'b0;
        s_next.lvl     = 4'h0;
      end else if (s_reg.lvl == 4'hf) begin
        s_next.lvl_out = 1'b1;
      end else begin
        s_next.lvl = s_reg.lvl + 4'h1;
      end
    end else if (btn_minus_i) begin
      if (s_reg.lvl_out) begin
        s_next.lvl_out = 1'b0;
        s_next.lvl     = 4'hf;
      end else if (s_reg.lvl == 4'h0) begin
        s_next.lvl_out = 1'b1;
      end else begin
        s_next.lvl = s_reg.lvl - 4'h1;
      end
    end
    eff_lvl = s_next.lvl_out ? active_level_i : s_next.lvl;
    s_next.lvl_disp = eff_lvl;
    s_next.rd_level = eff_lvl;
    s_next.rd_reg   = s_next.src[2:0];

    if (btn_decode_i) begin
      s_next.decode = !s_reg.decode;
    end

    stop_enter      = cpu_stop_i && !s_reg.was_stop;
    s_next.was_stop = cpu_stop_i;
    if (stop_enter) begin
      s_next.exam_latch = `FP_RST_ADDR;
    end
    if (console_exam_i) begin
      s_next.exam_latch = console_addr_i;
    end
    if (btn_set_addr_i && cpu_stop_i) begin
      s_next.exam_latch = sw_i;
    end
    exam_src = cpu_stop_i ? s_next.exam_latch : sw_i;
    paging = s_reg.pg_lamp;
    if (paging) begin
      s_next.exam_addr  = {2'b00, exam_src[15:0]};
      s_next.page_table = exam_src[17:`FP_SW_PT_LSB];
    end else begin
      s_next.exam_addr  = exam_src;
      s_next.page_table = 2'b00;
    end

    if (ref_valid_i && !ref_dma_i && !ref_fetch_i) begin
      s_next.adr = ref_addr_i;
    end
    if (ref_valid_i && ref_fetch_i) begin
      s_next.padr = ref_addr_i;
    end
    if (data_valid_i) begin
      s_next.data = data_i;
    end
    if (panel_ack_i) begin
      s_next.exm_word = exm_word_i;
      s_next.lvl_word = level_word_i;
    end

    if (btn_mclear_i) begin
      s_next.mclear  = 1'b1;
      s_next.pie_clr = 1'b1;
      s_next.comm    = 1'b1;
      s_next.mc_lamp = 1'b0;
    end
    if (error_i) begin
      s_next.mc_lamp = 1'b1;
    end

    if (btn_restart_i && cpu_stop_i) begin
      s_next.restart    = 1'b1;
      s_next.start_addr = `FP_RESTART_ADDR;
    end

    if (btn_load_i) begin
      s_next.load      = 1'b1;
      s_next.load_desc = load_descriptor_switches_i;
    end
    s_next.load_lamp = load_active_i;

    pie_lvl = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (priority_irq_enable_reg_i[i] && priority_irq_detect_reg_i[i]) begin
        pie_lvl = 4'(i);
      end
    end
    if (btn_single_i && cpu_stop_i) begin
      s_next.single    = 1'b1;
      s_next.run_level = pie_lvl;
    end
    // continue from stop, stop while running
    if (btn_cont_i && cpu_stop_i) begin
      s_next.cont      = 1'b1;
      s_next.run_level = pie_lvl;
    end
    if (btn_stop_i && !cpu_stop_i) begin
      s_next.stop = 1'b1;
    end

    if (btn_deposit_i && (s_reg.src == fp_pkg::FP_SRC_EXM)) begin
      s_next.mem_wr = 1'b1;
      s_next.wdata  = sw_i[15:0];
    end
    if (btn_enter_i && s_reg.src[3]) begin
      s_next.reg_wr = 1'b1;
      s_next.wdata  = sw_i[15:0];
    end

    // mode indicators, on wins over off
    if (interrupts_off_i) begin
      s_next.int_lamp = 1'b0;
    end
    if (interrupts_on_instruction_i) begin
      s_next.int_lamp = 1'b1;
    end
    if (paging_off_i) begin
      s_next.pg_lamp = 1'b0;
    end
    if (paging_on_instruction_i) begin
      s_next.pg_lamp = 1'b1;
    end

    unique case (s_next.src)
      fp_pkg::FP_SRC_ACTIVE: disp = {2'b00, glow};
      fp_pkg::FP_SRC_DMA:    disp = dma_addr_i;
      fp_pkg::FP_SRC_ADR:    disp = s_next.adr;
      fp_pkg::FP_SRC_PADR:   disp = s_next.padr;
      fp_pkg::FP_SRC_USER:   disp = {2'b00, s_next.user};
      fp_pkg::FP_SRC_DATA:   disp = {2'b00, s_next.data};
      fp_pkg::FP_SRC_EXM:    disp = {2'b00, s_next.exm_word};
      fp_pkg::FP_SRC_IR:     disp = {2'b00, instruction_register_view_i};
      default:               disp = {2'b00, s_next.lvl_word};
    endcase
    if (s_reg.decode && (s_next.src == fp_pkg::FP_SRC_DMA ||
                         s_next.src == fp_pkg::FP_SRC_ADR ||
                         s_next.src == fp_pkg::FP_SRC_PADR)) begin
      disp = dec_bus.seg;
    end
    // lamps refresh on service or reselect
    if (panel_ack_i || pick) begin
      s_next.lamps = disp;
    end

    // user write lands on the lamps
    lamp_wr = bus_wr_i && (bus_addr_i == `FP_OFS_LAMP);
    if (lamp_wr) begin
      s_next.user  = bus_wdata_i;
      s_next.lamps = {2'b00, bus_wdata_i};
    end

    s_next.rdata = 18'h0_0000;
    if (bus_rd_i) begin
      unique case (bus_addr_i)
        `FP_OFS_SWITCH: s_next.rdata = sw_i;
        `FP_OFS_LAMP:   s_next.rdata = {2'b00, s_reg.user};
        `FP_OFS_STATUS: begin
          s_next.rdata[`FP_ST_STOP]    = cpu_stop_i;
          s_next.rdata[`FP_ST_DECODE]  = s_reg.decode;
          s_next.rdata[`FP_ST_INT]     = s_reg.int_lamp;
          s_next.rdata[`FP_ST_PAGING]  = s_reg.pg_lamp;
          s_next.rdata[`FP_ST_LVL_LSB +: 4] = s_reg.lvl_disp;
          s_next.rdata[`FP_ST_SRC_LSB +: 4] = s_reg.src;
          s_next.rdata[`FP_ST_LVL_OUT] = s_reg.lvl_out;
        end
        default:        s_next.rdata = 18'h0_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // whole panel state; selection starts on active levels
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg           <= '0;
      s_reg.sel_lamps <= 16'h0001;
      s_reg.was_stop  <= 1'b1;  // no clear pulse straight out of reset
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------------
  assign bus_rdata_o   = s_reg.rdata;
  assign lamps_o       = s_reg.lamps;
  assign sel_lamps_o   = s_reg.sel_lamps;
  assign level_disp_o  = s_reg.lvl_disp;
  assign mclear_lamp_o = s_reg.mc_lamp;
  assign load_lamp_o   = s_reg.load_lamp;
  assign decode_lamp_o = s_reg.decode;
  assign cont_lamp_o   = !s_reg.was_stop;
  assign stop_lamp_o   = s_reg.was_stop;
  assign int_lamp_o    = s_reg.int_lamp;
  assign paging_lamp_o = s_reg.pg_lamp;
  assign panel_irq_o   = s_reg.irq;
  assign exam_addr_o   = s_reg.exam_addr;
  assign page_table_o  = s_reg.page_table;
  assign rd_level_o    = s_reg.rd_level;
  assign rd_reg_o      = s_reg.rd_reg;
  assign wdata_o       = s_reg.wdata;
  assign mem_wr_o      = s_reg.mem_wr;
  assign reg_wr_o      = s_reg.reg_wr;
  assign mclear_o      = s_reg.mclear;
  assign pie_clear_o   = s_reg.pie_clr;
  assign operator_comm_microprogram_o = s_reg.comm;
  assign restart_o     = s_reg.restart;
  assign start_addr_o  = s_reg.start_addr;
  assign load_o        = s_reg.load;
  assign load_desc_o   = s_reg.load_desc;
  assign single_o      = s_reg.single;
  assign cont_o        = s_reg.cont;
  assign stop_o        = s_reg.stop;
  assign run_level_o   = s_reg.run_level;

endmodule : fp_panel

//--- testbench/fp_panel_checker.sv
// Purpose: port assertions for fp_panel
// Assumes: one clock, reset active low
// Notes:   bound below
`timescale 1ns/1ns
module fp_panel_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        bus_rd_i,
  input wire logic [17:0] bus_rdata_o,
  input wire logic        btn_restart_i,
  input wire logic        btn_mclear_i,
  input wire logic        btn_deposit_i,
  input wire logic        btn_set_addr_i,
  input wire logic        console_exam_i,
  input wire logic        error_i,
  input wire logic        cpu_stop_i,
  input wire logic        restart_o,
  input wire logic [15:0] start_addr_o,
  input wire logic [15:0] sel_lamps_o,
  input wire logic        mem_wr_o,
  input wire logic        mclear_o,
  input wire logic        pie_clear_o,
  input wire logic        operator_comm_microprogram_o,
  input wire logic        mclear_lamp_o,
  input wire logic [17:0] exam_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_rd_idle_zero: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 0)
    else $error("read data without read");
  a_restart_addr: assert property (restart_o |-> start_addr_o == 16'h0014)
    else $error("restart address wrong");
  a_restart_run: assert property (btn_restart_i && !cpu_stop_i |=> !restart_o)
    else $error("restart while running");
  a_sel_onehot: assert property ($onehot(sel_lamps_o))
    else $error("selector lamps not one-hot");
  a_deposit_cause: assert property (mem_wr_o |-> $past(btn_deposit_i))
    else $error("memory write without deposit");
  a_mclear_pulse: assert property (btn_mclear_i |=> mclear_o && pie_clear_o
    && operator_comm_microprogram_o)
    else $error("master clear outputs missing");
  a_err_lamp_set: assert property (error_i |=> mclear_lamp_o)
    else $error("error lamp not lit");
  a_err_lamp_clr: assert property (btn_mclear_i && !error_i |=> !mclear_lamp_o)
    else $error("error lamp not cleared");
  a_stop_clear: assert property ($rose(cpu_stop_i) && !btn_set_addr_i
    && !console_exam_i |=> exam_addr_o == 0)
    else $error("examine address not cleared");
endmodule : fp_panel_checker
bind fp_panel fp_panel_checker u_chk (.*);

//--- testbench/fp_cpu_model.sv
// Purpose: cpu side that services the panel tick
// Assumes: word at an address is address xor a constant
// Notes:   ack four cycles after the request
`timescale 1ns/1ns
module fp_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        panel_irq_o,
  input  wire logic [17:0] exam_addr_o,
  output logic             panel_ack_i,
  output logic      [15:0] exm_word_i,
  output logic      [15:0] level_word_i
);
  logic [1:0] wait_reg;
  // delayed service of each tick request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_reg <= 2'd0;
      panel_ack_i <= 1'b0;
    end else begin
      wait_reg <= (panel_irq_o && !panel_ack_i) ? wait_reg + 2'd1 : 2'd0;
      panel_ack_i <= wait_reg == 2'd3;
    end
  end
  assign exm_word_i = exam_addr_o[15:0] ^ 16'h5a5a;
  assign level_word_i = 16'h0c0c;
endmodule : fp_cpu_model

//--- testbench/fp_panel_test.sv
// Purpose: self-checking bench for fp_panel
// Assumes: short tick and glow counts
// Notes:   drives change one ns after the edge
`timescale 1ns/1ns
module fp_panel_test;
  typedef struct packed {
    logic w; logic [3:0] a; logic [15:0] d; logic [17:0] e;
  } fpt_row_t;
  logic clk_i = 0, rstn_i = 0, cpu_stop_i = 1;
  logic [17:0] sw_i = 18'h2_abcd, dma_addr_i = 0, ref_addr_i = 0;
  logic [17:0] console_addr_i = 0;
  logic [15:0] sel_btn_i = 0, load_descriptor_switches_i = 0, data_i = 0;
  logic [15:0] priority_irq_enable_reg_i = 0, bus_wdata_i = 0;
  logic [15:0] priority_irq_detect_reg_i = 0, instruction_register_view_i = 0;
  logic [3:0] active_level_i = 4'h9, bus_addr_i = 0;
  logic btn_mclear_i = 0, btn_restart_i = 0, btn_load_i = 0, btn_decode_i = 0;
  logic btn_set_addr_i = 0, btn_deposit_i = 0, btn_enter_i = 0;
  logic btn_single_i = 0, btn_cont_i = 0, btn_stop_i = 0, btn_plus_i = 0;
  logic btn_minus_i = 0, ref_valid_i = 0, ref_dma_i = 0, ref_fetch_i = 0;
  logic data_valid_i = 0, console_exam_i = 0, error_i = 0, load_active_i = 0;
  logic interrupts_on_instruction_i = 0, interrupts_off_i = 0;
  logic paging_on_instruction_i = 0, paging_off_i = 0, bus_wr_i = 0;
  logic bus_rd_i = 0;
  logic [17:0] bus_rdata_o, lamps_o, exam_addr_o;
  logic [15:0] exm_word_i, level_word_i, sel_lamps_o, wdata_o;
  logic [15:0] start_addr_o, load_desc_o;
  logic [3:0] level_disp_o, rd_level_o, run_level_o;
  logic [2:0] rd_reg_o;
  logic [1:0] page_table_o;
  logic panel_ack_i, mclear_lamp_o, load_lamp_o, decode_lamp_o, cont_lamp_o;
  logic stop_lamp_o, int_lamp_o, paging_lamp_o, panel_irq_o, mem_wr_o;
  logic reg_wr_o, mclear_o, pie_clear_o, operator_comm_microprogram_o;
  logic restart_o, load_o, single_o, cont_o, stop_o;
  int errors = 0, checks = 0;
  fpt_row_t rows [5] = '{'{1'b1, 4'h4, 16'h1234, 18'h0_0000},
    '{1'b0, 4'h4, 16'h0000, 18'h0_1234}, '{1'b0, 4'h0, 16'h0000, 18'h2_abcd},
    '{1'b1, 4'h0, 16'hffff, 18'h0_0000}, '{1'b0, 4'hc, 16'h0000, 18'h0_0000}};

  fp_panel #(.CNT_W(5), .TICK_CYC(20), .GLOW_W(4), .GLOW_CYC(8)) dut (.*);
  fp_cpu_model u_cpu (.*);

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic bus(input fpt_row_t r);
    bus_wr_i <= r.w;
    bus_rd_i <= !r.w;
    bus_addr_i <= r.a;
    bus_wdata_i <= r.d;
    step;
    if (!r.w) chk("rdata", r.e, bus_rdata_o);
  endtask : bus
  task automatic wait_irq(input logic v);
    repeat (100) if (panel_irq_o !== v) step;
    chk("irq", v, panel_irq_o);
  endtask : wait_irq

  // clock and watchdog
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #20000;
    errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rstn_i <= 1;
    step;
    chk("sel", 18'h0_0001, sel_lamps_o);
    chk("stop lamp", 18'h0_0001, stop_lamp_o);
    foreach (rows[i]) bus(rows[i]);
    {bus_wr_i, bus_rd_i} <= 2'h0;
    chk("lamps user", 18'h0_1234, lamps_o);
    btn_restart_i <= 1;
    step;
    chk("restart", 18'h0_0001, restart_o);
    chk("start", 18'h0_0014, start_addr_o);
    cpu_stop_i <= 0;
    btn_restart_i <= 1;
    step;
    btn_restart_i <= 0;
    chk("restart run", 18'h0_0000, restart_o);
    step;
    chk("exam run", 18'h2_abcd, exam_addr_o);
    cpu_stop_i <= 1;
    step;
    step;
    chk("exam clr", 18'h0_0000, exam_addr_o);
    sel_btn_i <= 16'h0040;
    sw_i <= 18'h0_0123;
    btn_set_addr_i <= 1;
    step;
    {sel_btn_i, btn_set_addr_i} <= 0;
    btn_deposit_i <= 1;
    chk("sel exm", 18'h0_0040, sel_lamps_o);
    step;
    btn_deposit_i <= 0;
    chk("exam set", 18'h0_0123, exam_addr_o);
    chk("mem wr", 18'h0_0001, mem_wr_o);
    chk("wdata", 18'h0_0123, wdata_o);
    wait_irq(1);
    wait_irq(0);
    chk("lamps exm", 18'h0_5b79, lamps_o);
    sel_btn_i <= 16'h0001;
    step;
    sel_btn_i <= 0;
    btn_deposit_i <= 1;
    step;
    btn_deposit_i <= 0;
    chk("mem wr off", 18'h0_0000, mem_wr_o);
    btn_mclear_i <= 1;
    step;
    btn_mclear_i <= 0;
    chk("mclear", 18'h0_0007, {mclear_o, pie_clear_o,
      operator_comm_microprogram_o});
    error_i <= 1;
    step;
    error_i <= 0;
    btn_mclear_i <= 1;
    chk("err lamp", 18'h0_0001, mclear_lamp_o);
    step;
    btn_mclear_i <= 0;
    btn_minus_i <= 1;
    chk("err lamp clr", 18'h0_0000, mclear_lamp_o);
    step;
    chk("lvl out", 18'h0_0009, level_disp_o);
    step;
    btn_minus_i <= 0;
    chk("lvl 15", 18'h0_000f, level_disp_o);
    {cpu_stop_i, ref_addr_i, ref_valid_i, btn_decode_i} <= {19'h0_5123, 2'b11};
    interrupts_on_instruction_i <= 1;
    step;
    {ref_valid_i, btn_decode_i, interrupts_on_instruction_i} <= 0;
    sel_btn_i <= 16'h0004;
    chk("int lamp", 18'h0_0001, int_lamp_o);
    step;
    sel_btn_i <= 0;
    chk("decode", 18'h0_0020, lamps_o);
    {cpu_stop_i, btn_cont_i, btn_load_i} <= 3'h7;
    load_descriptor_switches_i <= 16'h00b0;
    priority_irq_enable_reg_i <= 16'h00a0;
    priority_irq_detect_reg_i <= 16'h0030;
    step;
    chk("cont", 18'h0_0015, {cont_o, run_level_o});
    chk("load", 18'h1_00b0, {load_o, load_desc_o});
    tally_and_finish;
  end
endmodule : fp_panel_test
